/* File: hw/tofcfg_bank.sv */
// serial register bank: hit waves, comparator offsets, event timing rates
//
// Overview of operation
// - third hit wave field 13:8, codes 0..5 select wave 5, else own number
// - fourth hit wave field 5:0, codes 0..6 select wave 6, else own number
// - fifth hit wave field 13:8, codes 0..7 select wave 7, else own number
// - sixth hit wave field 5:0, codes 0..8 select wave 8, else own number
// - return offsets bits 15:8 are signed steps about base 1152
// - upstream initial offset bits 6:0 unsigned step count 0..127
// - downstream initial offset bits 6:0 unsigned step count 0..127
// - rising edge gives 1152 plus code, falling gives 1151 minus code
// - difference runs every half second times one plus code, plus random
// - temperature runs every one plus code seconds, plus random
// - stop polarity 0 selects rising slope, 1 selects falling slope
`timescale 1ns/1ps
`include "tofcfg_consts.svh"
module tofcfg_bank
   import tofcfg_pkg::*;
#(
   parameter int TICK_CYCLES = `TOFCFG_TICK_CYCLES
)
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   input wire logic stop_edge_polarity,
   input wire logic event_cmd_both,
   input wire logic event_cmd_flow_only,
   input wire logic event_cmd_temp_only,
   input wire logic event_halt,
   output logic [5:0] third_hit_wave,
   output logic [5:0] fourth_hit_wave,
   output logic [5:0] fifth_hit_wave,
   output logic [5:0] sixth_hit_wave,
   output logic signed [7:0] up_return_offset,
   output logic signed [7:0] down_return_offset,
   output logic [10:0] up_return_level,
   output logic [10:0] down_return_level,
   output logic [6:0] up_initial_offset,
   output logic [6:0] down_initial_offset,
   output logic [10:0] up_initial_level,
   output logic [10:0] down_initial_level,
   output logic [4:0] diff_rate_code,
   output logic [6:0] temp_rate_code,
   output logic diff_meas_start,
   output logic temp_meas_start
);

////////////////////////////////////////////////////////////////////////////
function automatic logic [5:0] wave_sel(input logic [5:0] code,
                                        input logic [5:0] floor_wave);
   wave_sel = (code < floor_wave) ? floor_wave : code;
endfunction

function automatic logic [2:0] reg_idx(input logic [6:0] addr);
   reg_idx = 3'(addr - `TOFCFG_OFF_HIT34);
endfunction

function automatic logic addr_ok(input logic [6:0] addr);
   addr_ok = (addr >= `TOFCFG_OFF_HIT34) && (addr <= `TOFCFG_OFF_EVT1);
endfunction

function automatic logic [15:0] wr_mask(input logic [6:0] addr);
   if (addr == `TOFCFG_OFF_UPOFF || addr == `TOFCFG_OFF_DNOFF)
      wr_mask = `TOFCFG_MASK_OFFS;
   else if (addr == `TOFCFG_OFF_EVT1)
      wr_mask = `TOFCFG_MASK_EVT1;
   else
      wr_mask = `TOFCFG_MASK_WAVE;
endfunction

function automatic logic [10:0] init_level(input logic [6:0] code,
                                           input logic falling);
   if (falling)
      init_level = `TOFCFG_BASE_FALL - {4'h0, code};
   else
      init_level = `TOFCFG_BASE_RISE + {4'h0, code};
endfunction

function automatic logic [10:0] ret_level(input logic [7:0] code);
   ret_level = `TOFCFG_BASE_RISE + {{3{code[7]}}, code};
endfunction

////////////////////////////////////////////////////////////////////////////
// pin synchronisers, a change counts once stages two and three agree
logic [2:0] sclk_s_r;
logic [2:0] cs_s_r;
logic [2:0] sdi_s_r;
logic sclk_f_r;
logic cs_f_r;
logic sdi_f_r;
logic sclk_rise;
logic sclk_fall;

always_ff @(posedge core_clk or negedge resetn)
begin
   if (!resetn)
   begin
      sclk_s_r <= 3'h0;
      cs_s_r <= 3'h7;
      sdi_s_r <= 3'h0;
      sclk_f_r <= 1'b0;
      cs_f_r <= 1'b1;
      sdi_f_r <= 1'b0;
   end
   else if (clk_en)
   begin
      sclk_s_r <= {sclk_s_r[1:0], spi_sclk};
      cs_s_r <= {cs_s_r[1:0], spi_cs_n};
      sdi_s_r <= {sdi_s_r[1:0], spi_sdi};
      if (sclk_s_r[1] == sclk_s_r[2])
         sclk_f_r <= sclk_s_r[2];
      if (cs_s_r[1] == cs_s_r[2])
         cs_f_r <= cs_s_r[2];
      if (sdi_s_r[1] == sdi_s_r[2])
         sdi_f_r <= sdi_s_r[2];
   end
end

assign sclk_rise = (sclk_s_r[1] == sclk_s_r[2]) && sclk_s_r[2] && !sclk_f_r;
assign sclk_fall = (sclk_s_r[1] == sclk_s_r[2]) && !sclk_s_r[2] && sclk_f_r;

////////////////////////////////////////////////////////////////////////////
// serial frame: 8-bit opcode then 16-bit data, msb first
tofcfg_phase_t phase_r;
logic [4:0] bit_cnt_r;
logic [14:0] shin_r;
logic [7:0] op_r;
logic [15:0] shout_r;
tofcfg_word_t regs_r [`TOFCFG_NREGS];
logic [7:0] op_nxt;
logic [15:0] data_nxt;

assign op_nxt = {shin_r[6:0], sdi_f_r};
assign data_nxt = {shin_r[14:0], sdi_f_r};

always_ff @(posedge core_clk or negedge resetn)
begin
   if (!resetn)
   begin
      phase_r <= TOFCFG_IDLE;
      bit_cnt_r <= 5'h00;
      shin_r <= 15'h0000;
      op_r <= 8'h00;
   end
   else if (clk_en)
   begin
      if (cs_f_r)
      begin
         phase_r <= TOFCFG_IDLE;
         bit_cnt_r <= 5'h00;
      end
      else if (phase_r == TOFCFG_IDLE)
         phase_r <= TOFCFG_OPCODE;
      else if (sclk_rise)
      begin
         shin_r <= data_nxt[14:0];
         if (bit_cnt_r != 5'd24)
            bit_cnt_r <= bit_cnt_r + 5'd1;
         if (phase_r == TOFCFG_OPCODE && bit_cnt_r == 5'd7)
         begin
            op_r <= op_nxt;
            phase_r <= TOFCFG_DATA;
         end
      end
   end
end

// register writes, commit on the 24th rising edge
always_ff @(posedge core_clk or negedge resetn)
begin
   if (!resetn)
   begin
      for (int i = 0; i < `TOFCFG_NREGS; i++)
         regs_r[i] <= `TOFCFG_RESET_VAL;
   end
   else if (clk_en && !cs_f_r && sclk_rise && phase_r == TOFCFG_DATA &&
            bit_cnt_r == 5'd23 && !op_r[`TOFCFG_OP_READ_BIT] &&
            addr_ok(op_r[6:0]))
      regs_r[reg_idx(op_r[6:0])] <= data_nxt & wr_mask(op_r[6:0]);
end

// read data loads at opcode end, shifts out on falling edges
always_ff @(posedge core_clk or negedge resetn)
begin
   if (!resetn)
   begin
      shout_r <= 16'h0000;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
   end
   else if (clk_en)
   begin
      spi_sdo_oe <= !cs_f_r;
      if (cs_f_r)
         spi_sdo <= 1'b0;
      else if (sclk_rise && phase_r == TOFCFG_OPCODE && bit_cnt_r == 5'd7)
      begin
         if (op_nxt[`TOFCFG_OP_READ_BIT] && addr_ok(op_nxt[6:0]))
            shout_r <= regs_r[reg_idx(op_nxt[6:0])];
         else
            shout_r <= 16'h0000;
      end
      else if (sclk_fall && phase_r == TOFCFG_DATA && bit_cnt_r <= 5'd23)
      begin
         spi_sdo <= shout_r[15];
         shout_r <= {shout_r[14:0], 1'b0};
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// decoded configuration towards the measurement engine
tofcfg_word_t w34;
tofcfg_word_t w56;
tofcfg_word_t wup;
tofcfg_word_t wdn;
tofcfg_word_t wev;

assign w34 = regs_r[0];
assign w56 = regs_r[1];
assign wup = regs_r[2];
assign wdn = regs_r[3];
assign wev = regs_r[4];

always_ff @(posedge core_clk or negedge resetn)
begin
   if (!resetn)
   begin
      third_hit_wave <= `TOFCFG_MIN_WAVE3;
      fourth_hit_wave <= `TOFCFG_MIN_WAVE4;
      fifth_hit_wave <= `TOFCFG_MIN_WAVE5;
      sixth_hit_wave <= `TOFCFG_MIN_WAVE6;
      up_return_offset <= 8'sh00;
      down_return_offset <= 8'sh00;
      up_return_level <= `TOFCFG_BASE_RISE;
      down_return_level <= `TOFCFG_BASE_RISE;
      up_initial_offset <= 7'h00;
      down_initial_offset <= 7'h00;
      up_initial_level <= `TOFCFG_BASE_RISE;
      down_initial_level <= `TOFCFG_BASE_RISE;
      diff_rate_code <= 5'h01;
      temp_rate_code <= 7'h01;
   end
   else if (clk_en)
   begin
      third_hit_wave <= wave_sel(w34[`TOFCFG_HI_WAVE_MSB:`TOFCFG_HI_WAVE_LSB],
                                 `TOFCFG_MIN_WAVE3);
      fourth_hit_wave <= wave_sel(w34[`TOFCFG_LO_WAVE_MSB:`TOFCFG_LO_WAVE_LSB],
                                  `TOFCFG_MIN_WAVE4);
      fifth_hit_wave <= wave_sel(w56[`TOFCFG_HI_WAVE_MSB:`TOFCFG_HI_WAVE_LSB],
                                 `TOFCFG_MIN_WAVE5);
      sixth_hit_wave <= wave_sel(w56[`TOFCFG_LO_WAVE_MSB:`TOFCFG_LO_WAVE_LSB],
                                 `TOFCFG_MIN_WAVE6);
      up_return_offset <= wup[`TOFCFG_RET_MSB:`TOFCFG_RET_LSB];
      down_return_offset <= wdn[`TOFCFG_RET_MSB:`TOFCFG_RET_LSB];
      up_return_level <= ret_level(wup[`TOFCFG_RET_MSB:`TOFCFG_RET_LSB]);
      down_return_level <= ret_level(wdn[`TOFCFG_RET_MSB:`TOFCFG_RET_LSB]);
      up_initial_offset <= wup[`TOFCFG_INIT_MSB:`TOFCFG_INIT_LSB];
      down_initial_offset <= wdn[`TOFCFG_INIT_MSB:`TOFCFG_INIT_LSB];
      up_initial_level <= init_level(wup[`TOFCFG_INIT_MSB:`TOFCFG_INIT_LSB],
                                     stop_edge_polarity);
      down_initial_level <= init_level(wdn[`TOFCFG_INIT_MSB:`TOFCFG_INIT_LSB],
                                       stop_edge_polarity);
      diff_rate_code <= 5'(wev[`TOFCFG_DIFF_MSB:`TOFCFG_DIFF_LSB]) + 5'd1;
      temp_rate_code <= 7'(wev[`TOFCFG_TEMP_MSB:`TOFCFG_TEMP_LSB]) + 7'd1;
   end
end

////////////////////////////////////////////////////////////////////////////
// event timing: tick base, randomiser and the two interval timers
logic [31:0] tick_cnt_r;
logic tick_r;
logic [7:0] lfsr_r;
logic diff_act_r;
logic temp_act_r;
logic [7:0] diff_cnt_r;
logic [10:0] temp_cnt_r;
logic [7:0] diff_load;
logic [10:0] temp_load;

assign diff_load = 8'(`TOFCFG_HALF_SEC_TICKS *
                      (wev[`TOFCFG_DIFF_MSB:`TOFCFG_DIFF_LSB] + 1)) +
                   {5'h00, lfsr_r[2:0]};
assign temp_load = 11'(`TOFCFG_SEC_TICKS *
                       (wev[`TOFCFG_TEMP_MSB:`TOFCFG_TEMP_LSB] + 1)) +
                   {8'h00, lfsr_r[5:3]};

always_ff @(posedge core_clk or negedge resetn)
begin
   if (!resetn)
   begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
      lfsr_r <= `TOFCFG_LFSR_SEED;
   end
   else if (clk_en)
   begin
      tick_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 :
                    tick_cnt_r + 32'h0000_0001;
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
   end
end

always_ff @(posedge core_clk or negedge resetn)
begin
   if (!resetn)
   begin
      diff_act_r <= 1'b0;
      diff_cnt_r <= 8'h00;
      diff_meas_start <= 1'b0;
   end
   else if (clk_en)
   begin
      diff_meas_start <= 1'b0;
      if (event_halt)
         diff_act_r <= 1'b0;
      else if (event_cmd_both || event_cmd_flow_only)
      begin
         diff_act_r <= 1'b1;
         diff_cnt_r <= diff_load;
      end
      else if (diff_act_r && tick_r)
      begin
         if (diff_cnt_r <= 8'd1)
         begin
            diff_meas_start <= 1'b1;
            diff_cnt_r <= diff_load;
         end
         else
            diff_cnt_r <= diff_cnt_r - 8'd1;
      end
   end
end

always_ff @(posedge core_clk or negedge resetn)
begin
   if (!resetn)
   begin
      temp_act_r <= 1'b0;
      temp_cnt_r <= 11'h000;
      temp_meas_start <= 1'b0;
   end
   else if (clk_en)
   begin
      temp_meas_start <= 1'b0;
      if (event_halt)
         temp_act_r <= 1'b0;
      else if (event_cmd_both || event_cmd_temp_only)
      begin
         temp_act_r <= 1'b1;
         temp_cnt_r <= temp_load;
      end
      else if (temp_act_r && tick_r)
      begin
         if (temp_cnt_r <= 11'd1)
         begin
            temp_meas_start <= 1'b1;
            temp_cnt_r <= temp_load;
         end
         else
            temp_cnt_r <= temp_cnt_r - 11'd1;
      end
   end
end

endmodule

/* File: hw/tofcfg_consts.svh */
// constants for the hit wave, comparator offset and event timing bank
`ifndef TOFCFG_CONSTS_SVH
`define TOFCFG_CONSTS_SVH
`define TOFCFG_CLK_HZ 25000000
`define TOFCFG_NREGS 5
`define TOFCFG_OFF_HIT34 7'h3b
`define TOFCFG_OFF_HIT56 7'h3c
`define TOFCFG_OFF_UPOFF 7'h3d
`define TOFCFG_OFF_DNOFF 7'h3e
`define TOFCFG_OFF_EVT1 7'h3f
`define TOFCFG_OP_READ_BIT 7
`define TOFCFG_RESET_VAL 16'h0000
`define TOFCFG_MASK_WAVE 16'h3f3f
`define TOFCFG_MASK_OFFS 16'hff7f
`define TOFCFG_MASK_EVT1 16'hfffe
`define TOFCFG_HI_WAVE_MSB 13
`define TOFCFG_HI_WAVE_LSB 8
`define TOFCFG_LO_WAVE_MSB 5
`define TOFCFG_LO_WAVE_LSB 0
`define TOFCFG_MIN_WAVE3 6'h05
`define TOFCFG_MIN_WAVE4 6'h06
`define TOFCFG_MIN_WAVE5 6'h07
`define TOFCFG_MIN_WAVE6 6'h08
`define TOFCFG_RET_MSB 15
`define TOFCFG_RET_LSB 8
`define TOFCFG_INIT_MSB 6
`define TOFCFG_INIT_LSB 0
`define TOFCFG_BASE_RISE 11'h480
`define TOFCFG_BASE_FALL 11'h47f
`define TOFCFG_DIFF_MSB 15
`define TOFCFG_DIFF_LSB 12
`define TOFCFG_TEMP_MSB 6
`define TOFCFG_TEMP_LSB 1
`define TOFCFG_TICK_US 62500
`define TOFCFG_TICK_CYCLES (`TOFCFG_TICK_US * (`TOFCFG_CLK_HZ / 1000000))
`define TOFCFG_HALF_SEC_TICKS 8
`define TOFCFG_SEC_TICKS 16
`define TOFCFG_LFSR_SEED 8'h01
`endif

/* File: hw/tofcfg_pkg.sv */
// types for the hit wave, comparator offset and event timing bank
package tofcfg_pkg;
   typedef enum logic [1:0] {TOFCFG_IDLE, TOFCFG_OPCODE, TOFCFG_DATA} tofcfg_phase_t;
   typedef logic [15:0] tofcfg_word_t;
endpackage

/* File: test/tofcfg_props.sv */
// port assertions for the configuration register bank
`timescale 1ns/1ps
module tofcfg_props (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic spi_sdo_oe,
   input wire logic stop_edge_polarity,
   input wire logic event_halt,
   input wire logic [5:0] third_hit_wave,
   input wire logic [5:0] fourth_hit_wave,
   input wire logic [5:0] fifth_hit_wave,
   input wire logic [5:0] sixth_hit_wave,
   input wire logic signed [7:0] up_return_offset,
   input wire logic signed [7:0] down_return_offset,
   input wire logic [10:0] up_return_level,
   input wire logic [10:0] down_return_level,
   input wire logic [6:0] up_initial_offset,
   input wire logic [6:0] down_initial_offset,
   input wire logic [10:0] up_initial_level,
   input wire logic [10:0] down_initial_level,
   input wire logic [4:0] diff_rate_code,
   input wire logic [6:0] temp_rate_code,
   input wire logic diff_meas_start,
   input wire logic temp_meas_start
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_no_diff;
      !diff_meas_start [*8];
   endsequence
   sequence s_no_temp;
      !temp_meas_start [*8];
   endsequence
   property p_wave_hi;
      third_hit_wave >= 6'h05 && fifth_hit_wave >= 6'h07;
   endproperty
   a_wave_hi: assert property (p_wave_hi) else $error("odd wave");
   property p_wave_lo;
      fourth_hit_wave >= 6'h06 && sixth_hit_wave >= 6'h08;
   endproperty
   a_wave_lo: assert property (p_wave_lo) else $error("even wave");
   property p_ret_level;
      up_return_level == 11'(11'sh480 + up_return_offset) &&
      down_return_level == 11'(11'sh480 + down_return_offset);
   endproperty
   a_ret_level: assert property (p_ret_level) else $error("ret level");
   property p_up_init;
      $past(resetn) |-> up_initial_level == ($past(stop_edge_polarity) ?
         11'h47f - 11'(up_initial_offset) : 11'h480 + 11'(up_initial_offset));
   endproperty
   a_up_init: assert property (p_up_init) else $error("up lvl");
   property p_dn_init;
      $past(resetn) |-> down_initial_level == ($past(stop_edge_polarity) ?
         11'h47f - 11'(down_initial_offset) :
         11'h480 + 11'(down_initial_offset));
   endproperty
   a_dn_init: assert property (p_dn_init) else $error("down level");
   property p_diff_gap;
      $rose(diff_meas_start) |=> s_no_diff;
   endproperty
   a_diff_gap: assert property (p_diff_gap) else $error("diff gap");
   property p_temp_gap;
      $rose(temp_meas_start) |=> s_no_temp;
   endproperty
   a_temp_gap: assert property (p_temp_gap) else $error("temp gap");
   property p_halt;
      event_halt |-> ##2 (s_no_diff and s_no_temp);
   endproperty
   a_halt: assert property (p_halt) else $error("run after halt");
   property p_reset;
      $rose(resetn) |-> third_hit_wave == 6'h05 && sixth_hit_wave == 6'h08
         && up_initial_level == 11'h480 && diff_rate_code == 5'h01
         && temp_rate_code == 7'h01 && !spi_sdo_oe;
   endproperty
   a_reset: assert property (p_reset) else $error("reset value");
endmodule
bind tofcfg_bank tofcfg_props tofcfg_props_inst (.*);

/* File: test/tofcfg_host.sv */
// host model driving the serial register port in mode 0
`timescale 1ns/1ps
module tofcfg_host (
   input wire logic core_clk,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi,
   input wire logic spi_sdo
);
   initial
   begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
   end
   task automatic step(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // phases of 6 clocks stay above the 4 clock minimum
   task automatic xfer(input logic [7:0] op, input logic [15:0] wd,
      output logic [15:0] rd);
      logic [23:0] f;
      f = {op, wd};
      rd = 16'h0000;
      step(2);
      spi_cs_n = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         step(6);
         spi_sclk = 1'b0;
         spi_sdi = f[i];
         step(6);
         spi_sclk = 1'b1;
         if (i < 16)
            rd[i] = spi_sdo;
      end
      step(6);
      spi_sclk = 1'b0;
      step(6);
      spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi;
      step(6);
   endtask
endmodule

/* File: test/tofcfg_bank_bench.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tofcfg_bank_bench import tofcfg_pkg::*;;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic clk_en = 1'b1;
   logic stop_edge_polarity = 1'b0;
   logic event_cmd_both = 1'b0;
   logic event_cmd_flow_only = 1'b0;
   logic event_cmd_temp_only = 1'b0;
   logic event_halt = 1'b0;
   logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
   logic [5:0] third_hit_wave, fourth_hit_wave, fifth_hit_wave;
   logic [5:0] sixth_hit_wave;
   logic signed [7:0] up_return_offset, down_return_offset;
   logic [10:0] up_return_level, down_return_level;
   logic [6:0] up_initial_offset, down_initial_offset;
   logic [10:0] up_initial_level, down_initial_level;
   logic [4:0] diff_rate_code;
   logic [6:0] temp_rate_code;
   logic diff_meas_start, temp_meas_start;
   int n_fail = 0;
   int n_compared = 0;
   tofcfg_bank #(.TICK_CYCLES(4)) tofcfg_bank_inst (.*);
   tofcfg_host tofcfg_host_inst (.*);
   always #20 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////
   task automatic cyc(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [7:0] op, input logic [15:0] e);
      tofcfg_word_t d;
      tofcfg_host_inst.xfer(op, 16'h0000, d);
      chk(d, e);
   endtask
   task automatic wr(input logic [7:0] op, input logic [15:0] v);
      tofcfg_word_t d;
      tofcfg_host_inst.xfer(op, v, d);
   endtask
   task automatic t_reset;
      for (int i = 0; i < 5; i++)
         rd(8'hbb + 8'(i), 16'h0000);
      rd(8'hc0, 16'h0000);
      wr(8'h3a, 16'hffff);
      rd(8'hba, 16'h0000);
      chk(16'(up_return_level), 16'h0480);
      chk(16'(spi_sdo_oe), 16'h0000);
   endtask
   task automatic t_waves;
      logic [5:0] cs [4] = '{6'h00, 6'h05, 6'h06, 6'h3c};
      logic [5:0] c;
      logic lo;
      foreach (cs[i])
      begin
         c = cs[i];
         lo = (c < 6'h05);
         wr(8'h3b, {2'b11, c, 2'b11, c + 6'h01});
         wr(8'h3c, {2'b11, c + 6'h02, 2'b11, c + 6'h03});
         rd(8'hbb, {2'b00, c, 2'b00, c + 6'h01});
         rd(8'hbc, {2'b00, c + 6'h02, 2'b00, c + 6'h03});
         chk(16'(third_hit_wave), 16'(lo ? 6'h05 : c));
         chk(16'(fourth_hit_wave), 16'(lo ? 6'h06 : c + 6'h01));
         chk(16'(fifth_hit_wave), 16'(lo ? 6'h07 : c + 6'h02));
         chk(16'(sixth_hit_wave), 16'(lo ? 6'h08 : c + 6'h03));
      end
   endtask
   task automatic t_offs;
      wr(8'h3d, 16'h80ff);
      wr(8'h3e, 16'h7f80);
      rd(8'hbd, 16'h807f);
      rd(8'hbe, 16'h7f00);
      chk({8'h00, up_return_offset}, 16'h0080);
      chk({8'h00, down_return_offset}, 16'h007f);
      chk(16'(up_return_level), 16'h0400);
      chk(16'(down_return_level), 16'h04ff);
      chk(16'(up_initial_offset), 16'h007f);
      chk(16'(up_initial_level), 16'h04ff);
      chk(16'(down_initial_level), 16'h0480);
      stop_edge_polarity = 1'b1;
      cyc(2);
      chk(16'(up_initial_level), 16'h0400);
      chk(16'(down_initial_level), 16'h047f);
      stop_edge_polarity = 1'b0;
   endtask
   task automatic gap(input logic [2:0] c, input int dl, dh, tl, th);
      int d;
      int t;
      int x;
      d = 0;
      t = 0;
      x = 0;
      {event_cmd_both, event_cmd_flow_only, event_cmd_temp_only} = c;
      cyc(1);
      {event_cmd_both, event_cmd_flow_only, event_cmd_temp_only} = 3'b000;
      for (int n = 1; n <= 200; n++)
      begin
         cyc(1);
         if (diff_meas_start === 1'b1 && d == 0)
            d = n;
         if (temp_meas_start === 1'b1 && t == 0)
            t = n;
      end
      event_halt = 1'b1;
      cyc(1);
      event_halt = 1'b0;
      cyc(2);
      for (int n = 0; n < 200; n++)
      begin
         cyc(1);
         if (diff_meas_start !== 1'b0 || temp_meas_start !== 1'b0)
            x = 1;
      end
      chk(16'(d < dl || d > dh || t < tl || t > th || x == 1), 16'h0000);
   endtask
   task automatic t_events;
      wr(8'h3f, 16'hffff);
      rd(8'hbf, 16'hfffe);
      chk(16'(diff_rate_code), 16'h0010);
      chk(16'(temp_rate_code), 16'h0040);
      wr(8'h3f, 16'h1002);
      chk(16'(diff_rate_code), 16'h0002);
      chk(16'(temp_rate_code), 16'h0002);
      gap(3'b100, 56, 100, 120, 164);
      gap(3'b010, 56, 100, 0, 0);
      gap(3'b001, 0, 0, 120, 164);
   endtask
   // frame sent while frozen must not land; mid-run reset clears the bank
   task automatic t_hold;
      wr(8'h3e, 16'h1234);
      clk_en = 1'b0;
      wr(8'h3e, 16'h5678);
      clk_en = 1'b1;
      cyc(2);
      rd(8'hbe, 16'h1234);
      chk(16'(down_initial_offset), 16'h0034);
      resetn = 1'b0;
      cyc(2);
      resetn = 1'b1;
      cyc(2);
      for (int i = 0; i < 5; i++)
         rd(8'hbb + 8'(i), 16'h0000);
      chk(16'(third_hit_wave), 16'h0005);
      chk(16'(down_initial_offset), 16'h0000);
      chk(16'(up_initial_level), 16'h0480);
   endtask
   task automatic give_verdict;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      cyc(5);
      resetn = 1'b1;
      cyc(2);
      t_reset();
      t_waves();
      t_offs();
      t_events();
      t_hold();
      give_verdict();
   end
   initial
   begin
      #2000000;
      n_fail++;
      give_verdict();
   end
endmodule
